// file: difm_field.sv
`timescale 1ns/1ns

module difm_field
(
    // Levels the bench wants on the contacts
    input wire logic [3:0] level_i,
    // Contact pins
    output logic terminal_one_o,
    output logic terminal_two_o,
    output logic [1:0] terminal_hi_o
);
    // Contacts move well off the clock edge, so the pins stay truly asynchronous
    assign #7 {terminal_hi_o, terminal_two_o, terminal_one_o} = level_i;
endmodule // difm_field

// file: difm_map.svh
`ifndef DIFM_MAP_SVH
`define DIFM_MAP_SVH

// Register byte offsets
`define DIFM_OFF_STATUS 8'h00
`define DIFM_OFF_SEL_ONE 8'h04
`define DIFM_OFF_SEL_TWO 8'h08
`define DIFM_OFF_EVT_STAT 8'h0c
`define DIFM_OFF_EVT_CLR 8'h10
`define DIFM_OFF_EVT_EN 8'h14

// Status word fields
`define DIFM_ST_READY_BIT 0
`define DIFM_ST_INPUT_LSB 1
`define DIFM_ST_AUX_LSB 5
`define DIFM_ST_SPARE 8'h00

// Selector range and reset values
`define DIFM_SEL_MAX 4'hd
`define DIFM_SEL_RESET 4'h0
`define DIFM_EVT_RESET 6'h00

// Event bits
`define DIFM_EVT_TERM_LSB 0
`define DIFM_EVT_FAULT_BIT 4
`define DIFM_EVT_CLEAR_BIT 5

// Bus responses
`define DIFM_RESP_OKAY 2'h0
`define DIFM_RESP_SLVERR 2'h2

`endif

// file: difm_pkg.sv
package difm_pkg;

    typedef enum logic [3:0] {
        SEL_DISABLE = 4'h0,
        SEL_START = 4'h1,
        SEL_COAST = 4'h2,
        SEL_STOP_OPT = 4'h3,
        SEL_START_COAST = 4'h4,
        SEL_START_STOP = 4'h5,
        SEL_RSVD_A = 4'h6,
        SEL_DUAL_RAMP = 4'h7,
        SEL_OVERLOAD_CLASS_SELECT = 4'h8,
        SEL_FAULT = 4'h9,
        SEL_FAULT_NC = 4'ha,
        SEL_CLEAR_FAULT = 4'hb,
        SEL_EMERG_RUN = 4'hc,
        SEL_RSVD_B = 4'hd
    } difm_sel_t;

    typedef struct packed {
        logic start;
        logic coast;
        logic soft_stop;
        logic mode_two;
        logic ol_two;
        logic fault;
        logic clear;
        logic emerg;
    } difm_act_t;

    typedef struct packed {
        logic [3:0] sync_a;
        logic [3:0] sync_b;
        logic [3:0] sync_c;
        logic [3:0] term;
        difm_sel_t sel_one;
        difm_sel_t sel_two;
        logic [5:0] evt_stat;
        logic [5:0] evt_en;
        difm_act_t act;
        logic irq;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } difm_state_t;

endpackage

// file: difm_top.sv
// Notes on behaviour
// - Status bit 0 is set while the module reports ready and clear otherwise.
// - Status bits 1 to 4 show digital inputs 1 to 4, one meaning the input is on.
// - Status bits 5 to 7 show auxiliary relay outputs 1 to 3, one meaning on.
// - Inputs 1 and 2 each have a writable selector taking 0 to 13 that resets to 0, disabled.
// - A disabled input is ignored and produces no control action.
// - Start function: a high terminal requests a motor start.
// - Coast function: a low terminal commands a coast stop.
// - Stop option function: a low terminal requests the configured stop manoeuvre.
// - Start/coast function: low stops the motor, high requests a start.
// - Start/stop function: low requests the stop manoeuvre, high requests a start.
// - Dual ramp function: low selects starting mode 1, high starting mode 2.
// - Overload select function: low selects overload class 1, high class 2.
// - Fault function: a low terminal forces a fault.
// - Clear fault function: a high terminal clears the latched fault.
// - Emergency run function: high permits emergency run but starts nothing.
`timescale 1ns/1ns
`include "difm_map.svh"

module difm_top
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Field terminals and module state
    input wire logic terminal_one_i,
    input wire logic terminal_two_i,
    input wire logic [1:0] terminal_hi_i,
    input wire logic module_ready_i,
    input wire logic [2:0] aux_relay_i,
    // Control actions to the starter, and the event interrupt
    output logic start_req_o,
    output logic coast_req_o,
    output logic soft_stop_req_o,
    output logic start_mode_two_o,
    output logic overload_class_select_o,
    output logic fault_force_o,
    output logic fault_clear_o,
    output logic emergency_run_o,
    output logic irq_o,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import difm_pkg::*;

    difm_state_t q;
    difm_state_t next_q;

    // Translate one terminal level through its selector
    function automatic difm_act_t map_terminal(input difm_sel_t sel, input logic lvl);
        difm_act_t a;
        a = '0;
        case (sel)
            SEL_START: a.start = lvl;
            SEL_COAST: a.coast = ~lvl;
            SEL_STOP_OPT: a.soft_stop = ~lvl;
            SEL_START_COAST:
            begin
                a.start = lvl;
                a.coast = ~lvl;
            end
            SEL_START_STOP:
            begin
                a.start = lvl;
                a.soft_stop = ~lvl;
            end
            SEL_DUAL_RAMP: a.mode_two = lvl;
            SEL_OVERLOAD_CLASS_SELECT: a.ol_two = lvl;
            SEL_FAULT: a.fault = ~lvl;
            // Normally closed contact: opening the loop is the healthy state
            SEL_FAULT_NC: a.fault = lvl;
            SEL_CLEAR_FAULT: a.clear = lvl;
            // Permit only; never folded into the start request
            SEL_EMERG_RUN: a.emerg = lvl;
            default: a = '0;
        endcase
        return a;
    endfunction

    // Writable selector keeps its value when the code is out of range
    function automatic difm_sel_t sel_write(input difm_sel_t old, input logic [31:0] d,
                                           input logic [3:0] strb);
        difm_sel_t r;
        r = old;
        if (strb[0] && d[31:4] == 28'h0000000 && d[3:0] <= `DIFM_SEL_MAX)
        begin
            r = difm_sel_t'(d[3:0]);
        end
        return r;
    endfunction

    logic [3:0] pins;
    difm_act_t act_one;
    difm_act_t act_two;
    difm_act_t act_all;
    logic [5:0] evt_set;
    logic [5:0] evt_clr;
    logic [15:0] status_word;
    logic do_write;

    assign pins = {terminal_hi_i, terminal_two_i, terminal_one_i};
    assign status_word = {`DIFM_ST_SPARE, aux_relay_i, q.term, module_ready_i};

    always_comb
    begin
        next_q = q;
        act_one = map_terminal(q.sel_one, q.term[0]);
        act_two = map_terminal(q.sel_two, q.term[1]);
        act_all = act_one | act_two;
        evt_set = '0;
        evt_clr = '0;
        do_write = 1'b0;

        // Three-stage pin sync; a level counts once stages two and three agree
        next_q.sync_a = pins;
        next_q.sync_b = q.sync_a;
        next_q.sync_c = q.sync_b;
        for (int i = 0; i < 4; i++)
        begin
            if (q.sync_b[i] == q.sync_c[i])
            begin
                next_q.term[i] = q.sync_c[i];
            end
        end

        next_q.act = act_all;
        evt_set[`DIFM_EVT_TERM_LSB +: 4] = next_q.term ^ q.term;
        evt_set[`DIFM_EVT_FAULT_BIT] = act_all.fault & ~q.act.fault;
        evt_set[`DIFM_EVT_CLEAR_BIT] = act_all.clear & ~q.act.clear;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && q.awready)
        begin
            next_q.aw_hold = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            next_q.w_hold = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
        begin
            next_q.bvalid = 1'b0;
        end
        if (q.aw_hold && q.w_hold && !q.bvalid)
        begin
            do_write = 1'b1;
            next_q.aw_hold = 1'b0;
            next_q.w_hold = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = `DIFM_RESP_OKAY;
            if (q.aw_addr[7:2] == `DIFM_OFF_SEL_ONE >> 2)
            begin
                next_q.sel_one = sel_write(q.sel_one, q.w_data, q.w_strb);
            end
            else if (q.aw_addr[7:2] == `DIFM_OFF_SEL_TWO >> 2)
            begin
                next_q.sel_two = sel_write(q.sel_two, q.w_data, q.w_strb);
            end
            else if (q.aw_addr[7:2] == `DIFM_OFF_EVT_CLR >> 2)
            begin
                if (q.w_strb[0])
                begin
                    evt_clr = q.w_data[5:0];
                end
            end
            else if (q.aw_addr[7:2] == `DIFM_OFF_EVT_EN >> 2)
            begin
                if (q.w_strb[0])
                begin
                    next_q.evt_en = q.w_data[5:0];
                end
            end
            else if (q.aw_addr[7:2] == `DIFM_OFF_STATUS >> 2
                     || q.aw_addr[7:2] == `DIFM_OFF_EVT_STAT >> 2)
            begin
                next_q.bresp = `DIFM_RESP_OKAY;
            end
            else
            begin
                next_q.bresp = `DIFM_RESP_SLVERR;
            end
        end
        next_q.awready = !next_q.aw_hold && !next_q.bvalid;
        next_q.wready = !next_q.w_hold && !next_q.bvalid;

        // Set wins over a clear arriving in the same cycle
        next_q.evt_stat = (q.evt_stat & ~evt_clr) | evt_set;
        next_q.irq = |(next_q.evt_stat & next_q.evt_en);

        // Read channel: one outstanding read, answered the cycle after the take
        if (q.rvalid && s_axi_rready)
        begin
            next_q.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            next_q.rvalid = 1'b1;
            next_q.rresp = `DIFM_RESP_OKAY;
            next_q.rdata = 32'h00000000;
            if (s_axi_araddr[7:2] == `DIFM_OFF_STATUS >> 2)
            begin
                next_q.rdata = {16'h0000, status_word};
            end
            else if (s_axi_araddr[7:2] == `DIFM_OFF_SEL_ONE >> 2)
            begin
                next_q.rdata = {28'h0000000, q.sel_one};
            end
            else if (s_axi_araddr[7:2] == `DIFM_OFF_SEL_TWO >> 2)
            begin
                next_q.rdata = {28'h0000000, q.sel_two};
            end
            else if (s_axi_araddr[7:2] == `DIFM_OFF_EVT_STAT >> 2)
            begin
                next_q.rdata = {26'h0000000, q.evt_stat};
            end
            else if (s_axi_araddr[7:2] == `DIFM_OFF_EVT_EN >> 2)
            begin
                next_q.rdata = {26'h0000000, q.evt_en};
            end
            else if (s_axi_araddr[7:2] == `DIFM_OFF_EVT_CLR >> 2)
            begin
                next_q.rdata = 32'h00000000;
            end
            else
            begin
                next_q.rresp = `DIFM_RESP_SLVERR;
            end
        end
        next_q.arready = !next_q.rvalid;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.sel_one <= difm_sel_t'(`DIFM_SEL_RESET);
            q.sel_two <= difm_sel_t'(`DIFM_SEL_RESET);
            q.evt_stat <= `DIFM_EVT_RESET;
            q.evt_en <= `DIFM_EVT_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign start_req_o = q.act.start;
    assign coast_req_o = q.act.coast;
    assign soft_stop_req_o = q.act.soft_stop;
    assign start_mode_two_o = q.act.mode_two;
    assign overload_class_select_o = q.act.ol_two;
    assign fault_force_o = q.act.fault;
    assign fault_clear_o = q.act.clear;
    assign emergency_run_o = q.act.emerg;
    assign irq_o = q.irq;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // Checks watch internal state directly; they sleep while reset is low
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_status_ready_bit: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `DIFM_OFF_STATUS
        |=> s_axi_rdata[`DIFM_ST_READY_BIT] == $past(module_ready_i))
        else $error("ready bit does not follow module ready");

    a_status_inputs_aux: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `DIFM_OFF_STATUS
        |=> s_axi_rdata[7:1] == {$past(aux_relay_i), $past(q.term)})
        else $error("status input or aux bits wrong");

    a_status_spare_zero: assert property (
        s_axi_rvalid && $past(s_axi_araddr) == `DIFM_OFF_STATUS && $past(s_axi_arready)
        |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("spare status bits not zero");

    a_term_sync_delay: assert property (
        $stable(terminal_one_i) [*5] |-> q.term[0] == terminal_one_i)
        else $error("terminal one not synchronised within five cycles");

    a_sel_range_kept: assert property (
        q.sel_one <= `DIFM_SEL_MAX && q.sel_two <= `DIFM_SEL_MAX)
        else $error("selector outside 0 to 13");

    a_disabled_no_act: assert property (
        (q.sel_one inside {SEL_DISABLE, SEL_RSVD_A, SEL_RSVD_B})
        && (q.sel_two inside {SEL_DISABLE, SEL_RSVD_A, SEL_RSVD_B})
        ##1 $stable(q.sel_one) && $stable(q.sel_two)
        |-> !start_req_o && !coast_req_o && !soft_stop_req_o && !fault_force_o
            && !fault_clear_o && !emergency_run_o)
        else $error("disabled input produced an action");

    a_start_level: assert property (
        q.sel_one == SEL_START && q.sel_two == SEL_DISABLE && q.term[0]
        |=> start_req_o)
        else $error("start not requested on high terminal");

    a_coast_level: assert property (
        (q.sel_one == SEL_COAST || q.sel_one == SEL_START_COAST) && !q.term[0]
        |=> coast_req_o)
        else $error("coast not commanded on low terminal");

    a_stop_option: assert property (
        (q.sel_two == SEL_STOP_OPT || q.sel_two == SEL_START_STOP) && !q.term[1]
        |=> soft_stop_req_o)
        else $error("stop manoeuvre not requested on low terminal");

    a_ramp_overload: assert property (
        q.sel_one == SEL_DUAL_RAMP && q.sel_two == SEL_OVERLOAD_CLASS_SELECT
        |=> start_mode_two_o == $past(q.term[0])
            && overload_class_select_o == $past(q.term[1]))
        else $error("ramp or overload class not following terminal");

    a_fault_force: assert property (
        q.sel_one == SEL_FAULT && q.sel_two == SEL_CLEAR_FAULT
        |=> fault_force_o == !$past(q.term[0]) && fault_clear_o == $past(q.term[1]))
        else $error("fault force or clear wrong");

    a_emerg_no_start: assert property (
        q.sel_one == SEL_EMERG_RUN && q.sel_two == SEL_EMERG_RUN
        |=> emergency_run_o == |$past(q.term[1:0]) && !start_req_o)
        else $error("emergency run misbehaves");

    a_irq_level: assert property (
        irq_o == |(q.evt_stat & q.evt_en))
        else $error("interrupt not tracking enabled status");

    // A change must latch in the same edge, even when a clear lands with it
    a_evt_term_set: assert property (
        q.term[0] != $past(q.term[0]) |-> q.evt_stat[`DIFM_EVT_TERM_LSB])
        else $error("terminal change not latched as event");

    a_write_commit: assert property (
        do_write |=> s_axi_bvalid)
        else $error("committed write gave no response");

    c_write_select: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
    c_start_seen: cover property (q.sel_one == SEL_START && start_req_o);
    c_irq_raised: cover property (!irq_o ##1 irq_o);
    c_slverr_read: cover property (s_axi_rvalid && s_axi_rresp == `DIFM_RESP_SLVERR);
    c_pair_or: cover property (q.sel_one == SEL_FAULT && fault_force_o && fault_clear_o);

endmodule // difm_top

// file: tb.sv
`timescale 1ns/1ns
`include "difm_map.svh"

module tb;
    import difm_pkg::*;
    logic sys_clk_i, rst_n_i, ready, t1, t2, irq, awv, wv, bry, arv, rry;
    logic [3:0] lv, strb;
    logic [1:0] thi;
    logic [2:0] aux;
    logic [7:0] awa, ara;
    wire logic [7:0] act;
    logic [31:0] wd;
    wire logic awr, wr_rdy, bv, arr, rv;
    wire logic [1:0] br, rr;
    wire logic [31:0] rdat;
    int bad_count, checks, cycles_run;

    difm_field i_difm_field (.level_i(lv), .terminal_one_o(t1), .terminal_two_o(t2),
        .terminal_hi_o(thi));
    difm_top i_difm_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .terminal_one_i(t1),
        .terminal_two_i(t2), .terminal_hi_i(thi), .module_ready_i(ready), .aux_relay_i(aux),
        .start_req_o(act[7]), .coast_req_o(act[6]), .soft_stop_req_o(act[5]),
        .start_mode_two_o(act[4]), .overload_class_select_o(act[3]),
        .fault_force_o(act[2]), .fault_clear_o(act[1]), .emergency_run_o(act[0]),
        .irq_o(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Address and data are offered together; each is dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge sys_clk_i);
        awa <= a;
        awv <= 1'b1;
        wd <= d;
        strb <= 4'hf;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge sys_clk_i);
            if (!ad && awr === 1'b1)
            begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (!dd && wr_rdy === 1'b1)
            begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge sys_clk_i); while (bv !== 1'b1);
        chk({30'h0, br}, {30'h0, er});
        bry <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk_i);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do @(posedge sys_clk_i); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge sys_clk_i); while (rv !== 1'b1);
        chk(rdat, ed);
        chk({30'h0, rr}, {30'h0, er});
        rry <= 1'b0;
    endtask

    // Bit order: start, coast, soft stop, mode two, class two, fault, clear, emergency
    function automatic logic [7:0] exp_act(input logic [3:0] c, input logic l);
        case (c)
            4'h1: exp_act = {l, 7'h00};
            4'h2: exp_act = {1'b0, !l, 6'h00};
            4'h3: exp_act = {2'h0, !l, 5'h00};
            4'h4: exp_act = {l, !l, 6'h00};
            4'h5: exp_act = {l, 1'b0, !l, 5'h00};
            4'h7: exp_act = {3'h0, l, 4'h0};
            4'h8: exp_act = {4'h0, l, 3'h0};
            4'h9: exp_act = {5'h00, !l, 2'h0};
            4'ha: exp_act = {5'h00, l, 2'h0};
            4'hb: exp_act = {6'h00, l, 1'b0};
            4'hc: exp_act = {7'h00, l};
            default: exp_act = 8'h00;
        endcase
    endfunction

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run needs under a thousand cycles
    always @(posedge sys_clk_i)
    begin
        cycles_run++;
        if (cycles_run == 8000)
        begin
            bad_count++;
            $display("unexpected at %0t: hang, got 0x%h expected 0x%h", $time, 0, 1);
            give_verdict;
        end
    end

    initial
    begin
        {rst_n_i, ready, aux, lv, awv, wv, bry, arv, rry} = '0;
        {awa, ara, wd, strb} = '0;
        bad_count = 0;
        checks = 0;
        cycles_run = 0;
        cyc(12);
        rst_n_i <= 1'b1;
        cyc(2);
        rd(`DIFM_OFF_STATUS, 32'h0, `DIFM_RESP_OKAY);
        rd(`DIFM_OFF_SEL_ONE, 32'h0, `DIFM_RESP_OKAY);
        rd(`DIFM_OFF_SEL_TWO, 32'h0, `DIFM_RESP_OKAY);
        rd(8'h18, 32'h0, `DIFM_RESP_SLVERR);
        wr(8'h18, 32'h5, `DIFM_RESP_SLVERR);
        $display("test reset done");
        ready <= 1'b1;
        aux <= 3'h5;
        lv <= 4'ha;
        cyc(8);
        wr(`DIFM_OFF_STATUS, 32'hffff, `DIFM_RESP_OKAY);
        rd(`DIFM_OFF_STATUS, {24'h0, 3'h5, 4'ha, 1'b1}, `DIFM_RESP_OKAY);
        ready <= 1'b0;
        aux <= 3'h2;
        lv <= 4'h5;
        cyc(8);
        rd(`DIFM_OFF_STATUS, {24'h0, 3'h2, 4'h5, 1'b0}, `DIFM_RESP_OKAY);
        lv <= 4'h0;
        $display("test status done");
        for (int t = 0; t < 2; t++)
        begin
            wr(t ? `DIFM_OFF_SEL_ONE : `DIFM_OFF_SEL_TWO, 32'h0, `DIFM_RESP_OKAY);
            for (int c = 0; c < 14; c++)
            begin
                wr(t ? `DIFM_OFF_SEL_TWO : `DIFM_OFF_SEL_ONE, c, `DIFM_RESP_OKAY);
                rd(t ? `DIFM_OFF_SEL_TWO : `DIFM_OFF_SEL_ONE, c, `DIFM_RESP_OKAY);
                for (int l = 0; l < 2; l++)
                begin
                    lv <= t ? {2'h0, l[0], 1'b0} : {3'h0, l[0]};
                    cyc(8);
                    chk({24'h0, act}, {24'h0, exp_act(c[3:0], l[0])});
                end
            end
        end
        lv <= 4'h0;
        $display("test functions done");
        wr(`DIFM_OFF_SEL_ONE, 32'h3, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_ONE, 32'he, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_ONE, 32'h13, `DIFM_RESP_OKAY);
        rd(`DIFM_OFF_SEL_ONE, 32'h3, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_ONE, 32'h0, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_TWO, 32'h0, `DIFM_RESP_OKAY);
        $display("test range done");
        wr(`DIFM_OFF_SEL_ONE, 32'h7, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_TWO, 32'h8, `DIFM_RESP_OKAY);
        lv <= 4'h3;
        cyc(8);
        chk({24'h0, act}, {24'h0, exp_act(4'h7, 1'b1) | exp_act(4'h8, 1'b1)});
        wr(`DIFM_OFF_SEL_ONE, 32'h9, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_TWO, 32'hb, `DIFM_RESP_OKAY);
        lv <= 4'h2;
        cyc(8);
        chk({24'h0, act}, {24'h0, exp_act(4'h9, 1'b0) | exp_act(4'hb, 1'b1)});
        wr(`DIFM_OFF_SEL_ONE, 32'hc, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_TWO, 32'hc, `DIFM_RESP_OKAY);
        lv <= 4'h1;
        cyc(8);
        chk({24'h0, act}, {24'h0, exp_act(4'hc, 1'b1) | exp_act(4'hc, 1'b0)});
        lv <= 4'h0;
        wr(`DIFM_OFF_SEL_ONE, 32'h0, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_SEL_TWO, 32'h0, `DIFM_RESP_OKAY);
        cyc(4);
        $display("test pairing done");
        wr(`DIFM_OFF_EVT_EN, 32'h1, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_EVT_CLR, 32'h3f, `DIFM_RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        lv <= 4'h1;
        cyc(10);
        chk({31'h0, irq}, 32'h1);
        rd(`DIFM_OFF_EVT_STAT, 32'h1, `DIFM_RESP_OKAY);
        rd(`DIFM_OFF_EVT_EN, 32'h1, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_EVT_CLR, 32'h1, `DIFM_RESP_OKAY);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        rd(`DIFM_OFF_EVT_CLR, 32'h0, `DIFM_RESP_OKAY);
        wr(`DIFM_OFF_EVT_EN, 32'h2, `DIFM_RESP_OKAY);
        lv <= 4'h0;
        cyc(10);
        chk({31'h0, irq}, 32'h0);
        rd(`DIFM_OFF_EVT_STAT, 32'h1, `DIFM_RESP_OKAY);
        lv <= 4'h2;
        cyc(10);
        chk({31'h0, irq}, 32'h1);
        rd(`DIFM_OFF_EVT_STAT, 32'h3, `DIFM_RESP_OKAY);
        $display("test interrupt done");
        give_verdict;
    end
endmodule // tb
